// file: hdl/adc_ctrl_params.svh
// Purpose: register map, field positions, reset values, counts
// Assumes: 32-bit APB, 12-bit byte address
// Notes:   counts are in sampling clock cycles
`ifndef ADC_CTRL_PARAMS_SVH
`define ADC_CTRL_PARAMS_SVH
`define ADC_AW             12
`define ADC_CTRL_OFS       12'h000
`define ADC_OVR_OFS        12'h004
`define ADC_SER_OFS        12'h008
`define ADC_STAT_OFS       12'h00C
`define ADC_CTRL_RST       32'h0000_0000
`define ADC_OVR_RST        32'h0000_0000
`define ADC_SER_RST        32'h0000_0000
`define ADC_CTRL_WMASK     32'h0000_0137
`define ADC_OVR_WMASK      32'h0000_30FF
`define ADC_SER_WMASK      32'h0000_0377
`define ADC_B_OVR_MODE     0
`define ADC_B_SYSREF_EN    1
`define ADC_B_OFFSET_BIN   2
`define ADC_B_DIV          4
`define ADC_B_PDOWN        8
`define ADC_B_OVR_THR      0
`define ADC_B_OVR_HOLD     12
`define ADC_B_AMP          0
`define ADC_B_DEEMPH       4
`define ADC_B_INV          8
`define ADC_DIV_1          2'h0
`define ADC_DIV_2          2'h1
`define ADC_DIV_4          2'h2
`define ADC_HOLD_0         4'h0
`define ADC_HOLD_1         4'h3
`define ADC_HOLD_2         4'h7
`define ADC_HOLD_3         4'hF
`define ADC_THR_SHIFT      7
`define ADC_PWRUP_CYCLES   9000000
`define ADC_FGCAL_CYCLES   1000000
`define ADC_BGCAL_CYCLES   375000000
`endif

// file: hdl/adc_ctrl_pkg.sv
// Purpose: shared types of the converter control block
// Assumes: constants live in adc_ctrl_params.svh
// Notes:   none
package adc_ctrl_pkg;
    typedef enum logic [1:0] {
        CAL_WAIT,
        CAL_FG,
        CAL_RUN,
        CAL_PDOWN
    } cal_state_e;
    typedef logic [15:0] sample_t;
endpackage

// file: hdl/core_ctl_if.sv
// Purpose: carrier between control top, over-range and calibration
// Assumes: single clock domain
// Notes:   frame_en equals sample_en (one sample per frame)
`timescale 1ns/1ps
`default_nettype none
interface core_ctl_if import adc_ctrl_pkg::*;;
    logic       sample_en;
    logic       frame_en;
    sample_t    core_data;
    logic [7:0] ovr_thr;
    logic [3:0] ovr_hold;
    logic       ovr_flag;
    logic       clk_ok;
    logic       pdown;
    logic       cal_done;
    logic       cal_fin;
    logic       cal_busy;
    logic       bg_active;
    logic       bg_settled;
    modport top (output sample_en, frame_en, core_data, ovr_thr, ovr_hold,
                 clk_ok, pdown, input ovr_flag, cal_done, cal_fin, cal_busy,
                 bg_active, bg_settled);
    modport ovr (input sample_en, frame_en, core_data, ovr_thr, ovr_hold,
                 output ovr_flag);
    modport cal (input sample_en, clk_ok, pdown, output cal_done, cal_fin,
                 cal_busy, bg_active, bg_settled);
endinterface
`default_nettype wire

// file: hdl/ovr_hold_det.sv
// Purpose: over-range compare and hold counter
// Assumes: core data is two's complement
// Notes:   flag sets on the sample's own clock edge
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctrl_params.svh"
module ovr_hold_det import adc_ctrl_pkg::*; (
    input  wire logic   i_ref_clk,
    input  wire logic   i_srst,
    core_ctl_if.ovr     ctl
);
    logic [3:0]  cnt_q;
    logic        flag_q;
    logic [15:0] inv;
    logic [16:0] mag;
    logic [16:0] lim;
    logic        above;
    logic        done;
    assign inv   = ~ctl.core_data;
    assign mag   = ctl.core_data[15] ? ({1'b0, inv} + 17'h00001)
                                     : {1'b0, ctl.core_data};
    // threshold counts in 128-code steps
    assign lim   = {2'h0, ctl.ovr_thr, 7'h00};
    assign above = mag > lim;
    assign done  = cnt_q == ctl.ovr_hold;
    assign ctl.ovr_flag = flag_q;
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            flag_q <= 1'b0;
            cnt_q  <= 4'h0;
        end else if (ctl.sample_en && above) begin
            flag_q <= 1'b1;
            cnt_q  <= 4'h0;
        end else if (flag_q && ctl.frame_en) begin
            if (done) begin
                flag_q <= 1'b0;
            end else begin
                cnt_q <= cnt_q + 4'h1;
            end
        end
    end
    property p_ovr_set;
        @(posedge i_ref_clk) disable iff (i_srst)
        ctl.sample_en && above |=> flag_q && cnt_q == 4'h0;
    endproperty
    a_ovr_set: assert property (p_ovr_set) else $error("flag not set");
    property p_ovr_hold;
        @(posedge i_ref_clk) disable iff (i_srst)
        $fell(flag_q) |-> $past(cnt_q) == $past(ctl.ovr_hold);
    endproperty
    a_ovr_hold: assert property (p_ovr_hold) else $error("early release");
endmodule // ovr_hold_det
`default_nettype wire

// file: hdl/cal_seq.sv
// Purpose: power-up wait, foreground and background calibration
// Assumes: counts advance on sampling clock enables
// Notes:   leaving power-down restarts foreground calibration
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctrl_params.svh"
module cal_seq import adc_ctrl_pkg::*; #(
    parameter int unsigned PWRUP_CYCLES = `ADC_PWRUP_CYCLES,
    parameter int unsigned FGCAL_CYCLES = `ADC_FGCAL_CYCLES,
    parameter int unsigned BGCAL_CYCLES = `ADC_BGCAL_CYCLES
) (
    input  wire logic   i_ref_clk,
    input  wire logic   i_srst,
    core_ctl_if.cal     ctl
);
    localparam logic [28:0] PW_END = 29'(PWRUP_CYCLES - 1);
    localparam logic [28:0] FG_END = 29'(FGCAL_CYCLES - 1);
    localparam logic [28:0] BG_END = 29'(BGCAL_CYCLES - 1);
    if (PWRUP_CYCLES == 0 || FGCAL_CYCLES == 0 || BGCAL_CYCLES == 0 ||
        BGCAL_CYCLES > 29'h1FFF_FFFF) begin : g_chk
        $error("cal_seq: counts out of range");
    end
    cal_state_e  st_q;
    logic [28:0] cnt_q;
    logic        done_q;
    logic        fin_q;
    logic        settled_q;
    logic        tick;
    assign tick           = ctl.sample_en;
    assign ctl.cal_done   = done_q;
    assign ctl.cal_fin    = fin_q;
    assign ctl.cal_busy   = st_q == CAL_FG;
    assign ctl.bg_active  = st_q == CAL_RUN;
    assign ctl.bg_settled = settled_q;
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            st_q      <= CAL_WAIT;
            cnt_q     <= 29'h0;
            done_q    <= 1'b0;
            fin_q     <= 1'b0;
            settled_q <= 1'b0;
        end else begin
            fin_q <= 1'b0;
            unique case (st_q)
                CAL_WAIT: begin
                    if (!ctl.clk_ok) begin
                        cnt_q <= 29'h0;
                    end else if (tick && cnt_q == PW_END) begin
                        st_q  <= CAL_FG;
                        cnt_q <= 29'h0;
                    end else if (tick) begin
                        cnt_q <= cnt_q + 29'h1;
                    end
                end
                CAL_FG: begin
                    if (ctl.pdown) begin
                        st_q <= CAL_PDOWN;
                    end else if (tick && cnt_q == FG_END) begin
                        st_q   <= CAL_RUN;
                        cnt_q  <= 29'h0;
                        done_q <= 1'b1;
                        fin_q  <= 1'b1;
                    end else if (tick) begin
                        cnt_q <= cnt_q + 29'h1;
                    end
                end
                CAL_RUN: begin
                    if (ctl.pdown) begin
                        st_q <= CAL_PDOWN;
                    end else if (tick && !settled_q) begin
                        settled_q <= cnt_q == BG_END;
                        cnt_q     <= cnt_q + 29'h1;
                    end
                end
                CAL_PDOWN: begin
                    done_q    <= 1'b0;
                    settled_q <= 1'b0;
                    cnt_q     <= 29'h0;
                    if (!ctl.pdown) begin
                        st_q <= CAL_FG;
                    end
                end
            endcase
        end
    end
    property p_fg_len;
        @(posedge i_ref_clk) disable iff (i_srst)
        $rose(done_q) |-> $past(cnt_q) == FG_END && $past(st_q) == CAL_FG;
    endproperty
    a_fg_len: assert property (p_fg_len) else $error("cal length wrong");
    property p_pwrup;
        @(posedge i_ref_clk) disable iff (i_srst)
        $past(st_q) == CAL_WAIT && st_q == CAL_FG |-> $past(cnt_q) == PW_END;
    endproperty
    a_pwrup: assert property (p_pwrup) else $error("power-up wait wrong");
endmodule // cal_seq
`default_nettype wire

// file: hdl/adc_ctrl_top.sv
// Purpose: digital control of a 16-bit converter core behind APB
// Assumes: all inputs synchronous to i_ref_clk, the input clock
// Notes:   serializer, 8b/10b and link layer sit outside
// Contract
// - serial-out pin is SPI data after reset
// - over-range flag rises without pipeline delay
// - threshold programmable in 128-code steps
// - hold counter runs after input falls back
// - hold of 0, 3, 7 or 15 frames
// - sampling clock divides input by 1, 2, 4
// - new divide ratio restarts link; recalibrate
// - reference input gated by software enable
// - reference gate disabled after reset
// - eight amplitude and eight de-emphasis settings
// - each lane polarity invertible independently
// - power-up waits nine million sampling cycles
// - foreground calibration takes one million cycles
// - background calibration runs in normal conversion
// - background calibration settles within 375 million
// - two's complement default, offset binary optional
// - each lane carries ten bits per sample
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctrl_params.svh"
module adc_ctrl_top import adc_ctrl_pkg::*; #(
    parameter int unsigned PWRUP_CYCLES = `ADC_PWRUP_CYCLES,
    parameter int unsigned FGCAL_CYCLES = `ADC_FGCAL_CYCLES,
    parameter int unsigned BGCAL_CYCLES = `ADC_BGCAL_CYCLES
) (
    input  wire logic                i_ref_clk,
    input  wire logic                i_srst,
    input  wire logic                i_psel,
    input  wire logic                i_penable,
    input  wire logic                i_pwrite,
    input  wire logic [`ADC_AW-1:0]  i_paddr,
    input  wire logic [31:0]         i_pwdata,
    input  wire logic [3:0]          i_pstrb,
    output var  logic [31:0]         o_prdata,
    output var  logic                o_pready,
    output var  logic                o_pslverr,
    input  wire logic                i_supply_clk_ok,
    input  wire logic [15:0]         i_core_data,
    input  wire logic                i_sysref,
    input  wire logic                i_spi_sdo,
    input  wire logic                i_spi_sdo_oe,
    output var  logic                o_serial_out_overrange_pin,
    output var  logic                o_serial_out_overrange_oe,
    output var  logic                o_sysref_gated,
    output var  logic                o_sample_en,
    output var  logic [15:0]         o_sample_data,
    output var  logic [7:0]          o_lane0_octet,
    output var  logic [7:0]          o_lane1_octet,
    output var  logic [1:0]          o_lane_polarity_invert,
    output var  logic [2:0]          o_driver_amplitude_setting,
    output var  logic [2:0]          o_driver_deemphasis_setting,
    output var  logic                o_link_reinit,
    output var  logic                o_bg_cal_active,
    output var  logic                o_core_power_down
);
    ////////////////////////////////////////////////////////////////////
    // register file
    logic [31:0] ctrl_q;
    logic [31:0] ovr_q;
    logic [31:0] ser_q;
    logic [31:0] prdata_q;
    logic [1:0]  div_q;
    logic [1:0]  cal_div_q;
    logic        reinit_q;
    logic [1:0]  pcnt_q;
    sample_t     sample_q;
    logic [31:0] bmask;
    logic [31:0] ctrl_d;
    logic [31:0] ovr_d;
    logic [31:0] ser_d;
    logic [31:0] stat_w;
    logic [31:0] rd_mux;
    logic        setup;
    logic        access;
    logic        wr;
    logic        hit_ctrl;
    logic        hit_ovr;
    logic        hit_ser;
    logic        hit_stat;
    logic        hit;
    logic        wr_ctrl;
    logic        wr_ovr;
    logic        wr_ser;
    logic [1:0]  div_new;
    logic        div_ok;
    logic        div_chg;
    logic        div_wr;
    logic [1:0]  pmask;
    logic        sample_en;
    logic        recal_need;
    logic        ovr_mode;
    sample_t     fmt_data;
    core_ctl_if ctl ();
    assign setup    = i_psel && !i_penable;
    assign access   = i_psel && i_penable;
    assign wr       = access && i_pwrite;
    assign hit_ctrl = i_paddr == `ADC_CTRL_OFS;
    assign hit_ovr  = i_paddr == `ADC_OVR_OFS;
    assign hit_ser  = i_paddr == `ADC_SER_OFS;
    assign hit_stat = i_paddr == `ADC_STAT_OFS;
    assign hit      = hit_ctrl || hit_ovr || hit_ser || hit_stat;
    assign wr_ctrl  = wr && hit_ctrl;
    assign wr_ovr   = wr && hit_ovr;
    assign wr_ser   = wr && hit_ser;
    assign bmask    = {{8{i_pstrb[3]}}, {8{i_pstrb[2]}},
                       {8{i_pstrb[1]}}, {8{i_pstrb[0]}}};
    // zero wait states; unmapped addresses answer with an error
    assign o_pready  = 1'b1;
    assign o_pslverr = access && !hit;
    assign o_prdata  = prdata_q;

    ////////////////////////////////////////////////////////////////////
    // write merging; the illegal divide code keeps the old ratio
    assign ctrl_d  = (ctrl_q & ~(bmask & `ADC_CTRL_WMASK)) |
                     (i_pwdata & bmask & `ADC_CTRL_WMASK);
    assign ovr_d   = (ovr_q & ~(bmask & `ADC_OVR_WMASK)) |
                     (i_pwdata & bmask & `ADC_OVR_WMASK);
    assign ser_d   = (ser_q & ~(bmask & `ADC_SER_WMASK)) |
                     (i_pwdata & bmask & `ADC_SER_WMASK);
    assign div_new = ctrl_d[`ADC_B_DIV +: 2];
    assign div_ok  = div_new != 2'h3;
    assign div_wr  = wr_ctrl && div_ok;
    assign div_chg = div_wr && div_new != div_q;
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            ctrl_q <= `ADC_CTRL_RST;
            ovr_q  <= `ADC_OVR_RST;
            ser_q  <= `ADC_SER_RST;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= div_ok ? ctrl_d
                                 : {ctrl_d[31:6], ctrl_q[5:4], ctrl_d[3:0]};
            end
            if (wr_ovr) begin
                ovr_q <= ovr_d;
            end
            if (wr_ser) begin
                ser_q <= ser_d;
            end
        end
    end
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            prdata_q <= 32'h0000_0000;
        end else if (setup && !i_pwrite) begin
            prdata_q <= rd_mux;
        end
    end
    assign rd_mux = hit_ctrl ? ctrl_q :
                    hit_ovr  ? ovr_q  :
                    hit_ser  ? ser_q  :
                    hit_stat ? stat_w : 32'h0000_0000;
    // calibration completion polled here
    assign recal_need = ctl.cal_done && cal_div_q != div_q;
    assign stat_w = {26'h0, recal_need, ctl.bg_settled, ctl.bg_active,
                     ctl.ovr_flag, ctl.cal_busy, ctl.cal_done};

    ////////////////////////////////////////////////////////////////////
    // input clock divider: sampling enable pulse
    assign div_q = ctrl_q[`ADC_B_DIV +: 2];
    assign pmask = div_q == `ADC_DIV_4 ? 2'h3 :
                   div_q == `ADC_DIV_2 ? 2'h1 : 2'h0;
    assign sample_en = pcnt_q == pmask;
    always_ff @(posedge i_ref_clk) begin
        if (i_srst || div_wr || sample_en) begin
            pcnt_q <= 2'h0;
        end else begin
            pcnt_q <= pcnt_q + 2'h1;
        end
    end
    // link restart on a changed ratio
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            reinit_q <= 1'b0;
        end else begin
            reinit_q <= div_chg;
        end
    end
    assign o_link_reinit = reinit_q;
    // remember the ratio in force at the last calibration
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            cal_div_q <= `ADC_DIV_1;
        end else if (ctl.cal_fin) begin
            cal_div_q <= div_q;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // sample path: format before framing and coding
    assign fmt_data = ctrl_q[`ADC_B_OFFSET_BIN]
                    ? {~i_core_data[15], i_core_data[14:0]}
                    : i_core_data;
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            sample_q <= 16'h0000;
        end else if (sample_en) begin
            sample_q <= fmt_data;
        end
    end
    assign o_sample_en   = sample_en;
    assign o_sample_data = sample_q;
    // one octet per lane per sample, ten line bits after coding
    assign o_lane0_octet = sample_q[15:8];
    assign o_lane1_octet = sample_q[7:0];
    assign o_driver_amplitude_setting  = ser_q[`ADC_B_AMP +: 3];
    assign o_driver_deemphasis_setting = ser_q[`ADC_B_DEEMPH +: 3];
    assign o_lane_polarity_invert      = ser_q[`ADC_B_INV +: 2];

    ////////////////////////////////////////////////////////////////////
    // reference detection gate; a plain AND keeps the path short
    assign o_sysref_gated = i_sysref && ctrl_q[`ADC_B_SYSREF_EN];
    // dual-mode pin: SPI data unless over-range mode selected
    assign ovr_mode = ctrl_q[`ADC_B_OVR_MODE];
    assign o_serial_out_overrange_pin = ovr_mode ? ctl.ovr_flag
                                                 : i_spi_sdo;
    assign o_serial_out_overrange_oe  = ovr_mode || i_spi_sdo_oe;

    ////////////////////////////////////////////////////////////////////
    // over-range and calibration engines
    assign ctl.sample_en = sample_en;
    assign ctl.frame_en  = sample_en;
    assign ctl.core_data = i_core_data;
    assign ctl.ovr_thr   = ovr_q[`ADC_B_OVR_THR +: 8];
    assign ctl.ovr_hold  = ovr_q[`ADC_B_OVR_HOLD +: 2] == 2'h3 ? `ADC_HOLD_3 :
                           ovr_q[`ADC_B_OVR_HOLD +: 2] == 2'h2 ? `ADC_HOLD_2 :
                           ovr_q[`ADC_B_OVR_HOLD +: 2] == 2'h1 ? `ADC_HOLD_1 :
                           `ADC_HOLD_0;
    assign ctl.clk_ok    = i_supply_clk_ok;
    assign ctl.pdown     = ctrl_q[`ADC_B_PDOWN];
    assign o_core_power_down = ctrl_q[`ADC_B_PDOWN];
    assign o_bg_cal_active   = ctl.bg_active;

    ovr_hold_det u_ovr (
        .i_ref_clk (i_ref_clk),
        .i_srst    (i_srst),
        .ctl       (ctl)
    );

    cal_seq #(
        .PWRUP_CYCLES (PWRUP_CYCLES),
        .FGCAL_CYCLES (FGCAL_CYCLES),
        .BGCAL_CYCLES (BGCAL_CYCLES)
    ) u_cal (
        .i_ref_clk (i_ref_clk),
        .i_srst    (i_srst),
        .ctl       (ctl)
    );
    ////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (i_srst);
    property p_pin_mode;
        !ovr_mode |-> o_serial_out_overrange_pin == i_spi_sdo &&
                      o_serial_out_overrange_oe == i_spi_sdo_oe;
    endproperty
    a_pin_mode: assert property (p_pin_mode) else $error("pin mode");
    property p_pin_ovr;
        ovr_mode && ctl.sample_en && u_ovr.above ##1 ovr_mode
            |-> o_serial_out_overrange_pin && o_serial_out_overrange_oe;
    endproperty
    a_pin_ovr: assert property (p_pin_ovr) else $error("ovr late");
    sequence s_quarter;
        (!sample_en)[*3] ##1 sample_en;
    endsequence
    property p_div2;
        disable iff (i_srst || wr_ctrl)
        div_q == `ADC_DIV_2 && sample_en |=> !sample_en ##1 sample_en;
    endproperty
    a_div2: assert property (p_div2) else $error("div2");

    property p_div4_gap;
        disable iff (i_srst || wr_ctrl)
        div_q == `ADC_DIV_4 && sample_en |=> s_quarter;
    endproperty
    a_div4_gap: assert property (p_div4_gap) else $error("div4");
    property p_div1;
        div_q == `ADC_DIV_1 |-> sample_en;
    endproperty
    a_div1: assert property (p_div1) else $error("div1");
    property p_reinit;
        div_chg |=> o_link_reinit ##1 !o_link_reinit || div_chg;
    endproperty
    a_reinit: assert property (p_reinit) else $error("no reinit");
    property p_gate;
        !ctrl_q[`ADC_B_SYSREF_EN] |-> !o_sysref_gated;
    endproperty
    a_gate: assert property (p_gate) else $error("ref leaks");
    property p_gate_rst;
        $fell(i_srst) |-> !ctrl_q[`ADC_B_SYSREF_EN];
    endproperty
    a_gate_rst: assert property (p_gate_rst) else $error("gate on");
    property p_fmt;
        sample_en |=> o_sample_data == ($past(ctrl_q[`ADC_B_OFFSET_BIN])
            ? {~$past(i_core_data[15]), $past(i_core_data[14:0])}
            : $past(i_core_data));
    endproperty
    a_fmt: assert property (p_fmt) else $error("format");
    property p_lane;
        o_lane_polarity_invert == ser_q[9:8] &&
        {o_lane0_octet, o_lane1_octet} == o_sample_data;
    endproperty
    a_lane: assert property (p_lane) else $error("lane map");
    property p_bg;
        o_bg_cal_active |-> ctl.cal_done && !o_core_power_down ||
                            $rose(o_core_power_down);
    endproperty
    a_bg: assert property (p_bg) else $error("bg cal");

    property p_div_keep;
        wr_ctrl && !div_ok |=> $stable(div_q);
    endproperty
    a_div_keep: assert property (p_div_keep) else $error("bad ratio taken");

    property p_reinit_cause;
        o_link_reinit |-> $past(div_chg);
    endproperty
    a_reinit_cause: assert property (p_reinit_cause) else $error("stray reinit");

    // reset must leave SPI pin mode, two's complement and no hold
    property p_rst_dflt;
        $fell(i_srst) |-> !ovr_mode && !ctrl_q[`ADC_B_OFFSET_BIN] &&
                          ctl.ovr_hold == `ADC_HOLD_0;
    endproperty
    a_rst_dflt: assert property (p_rst_dflt) else $error("reset defaults");

    property p_ovr_pin;
        ovr_mode |-> o_serial_out_overrange_oe &&
                     o_serial_out_overrange_pin == ctl.ovr_flag;
    endproperty
    a_ovr_pin: assert property (p_ovr_pin) else $error("ovr pin");

    // samples move only on the sampling enable
    property p_sample_hold;
        !sample_en |=> $stable(o_sample_data);
    endproperty
    a_sample_hold: assert property (p_sample_hold) else $error("sample moved");

    // an unmapped access must not land in any register
    property p_unmapped;
        access && !hit |=> $stable(ctrl_q) && $stable(ovr_q) && $stable(ser_q);
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped write");
endmodule // adc_ctrl_top
`default_nettype wire

// file: dv/lane_rx.sv
// Purpose: receiver stand-in rebuilding samples from both lanes
// Assumes: one octet per lane per frame, lane 0 carries the high byte
// Notes:   polarity flags are judged by the bench, not undone here
`timescale 1ns/1ps
`default_nettype none
module lane_rx (
    input  wire logic        i_ref_clk,
    input  wire logic        i_frame_en,
    input  wire logic [7:0]  i_lane0,
    input  wire logic [7:0]  i_lane1,
    output var  logic [15:0] o_rx_word
);
    always_ff @(posedge i_ref_clk) begin
        if (i_frame_en) begin
            o_rx_word <= {i_lane0, i_lane1};
        end
    end
endmodule // lane_rx
`default_nettype wire

// file: dv/adc_digital_control_features_tb.sv
// Purpose: register-level bench of the converter control block
// Assumes: short calibration counts, zero-wait APB slave
// Notes:   lane octets checked through the receiver stand-in
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctrl_params.svh"
module adc_digital_control_features_tb;
    logic        clk = 1'b0, srst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic        sysref = 1'b1, sdo = 1'b1, sdo_oe = 1'b0, ok = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [15:0] core = 16'h0000, sdata, rxw;
    logic [7:0]  l0, l1;
    logic [2:0]  amp, driver_deemphasis_setting;
    logic [1:0]  inv;
    logic        pready, perr, err, pin, oe, sgd, sen, reinit, bga, pd;
    logic [15:0] ov [9] = '{16'h0080, 16'h0081, 0, 0, 16'hFED4, 0, 0, 0, 0};
    logic        ex [9] = '{0, 1, 1, 1, 1, 1, 1, 1, 0};
    int          n_mismatch = 0, checks_done = 0, k;
    always #4 clk = ~clk;
    adc_ctrl_top #(.PWRUP_CYCLES(20), .FGCAL_CYCLES(10), .BGCAL_CYCLES(30)) dut (
        .i_ref_clk(clk), .i_srst(srst), .i_psel(psel), .i_penable(pen),
        .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(4'hF),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(perr), .i_supply_clk_ok(ok),
        .i_core_data(core), .i_sysref(sysref), .i_spi_sdo(sdo), .i_spi_sdo_oe(sdo_oe),
        .o_serial_out_overrange_pin(pin), .o_serial_out_overrange_oe(oe),
        .o_sysref_gated(sgd), .o_sample_en(sen), .o_sample_data(sdata),
        .o_lane0_octet(l0), .o_lane1_octet(l1), .o_lane_polarity_invert(inv),
        .o_driver_amplitude_setting(amp), .o_driver_deemphasis_setting(driver_deemphasis_setting),
        .o_link_reinit(reinit), .o_bg_cal_active(bga), .o_core_power_down(pd));
    lane_rx rx (.i_ref_clk(clk), .i_frame_en(sen), .i_lane0(l0), .i_lane1(l1), .o_rx_word(rxw));
    ////////////////////////////////////////////////////////////////////////////
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk); psel <= 1'b1; pwr <= w; paddr <= a; pwdata <= d;
        @(posedge clk); pen <= 1'b1;
        n = 0;
        do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 64);
        if (n >= 64) begin n_mismatch++; test_done(); end
        rd = prdata; err = perr; psel <= 1'b0; pen <= 1'b0;
    endtask
    task automatic poll(input int b);
        int n;
        n = 0;
        do begin apb(0, `ADC_STAT_OFS, 0); n++; end while (rd[b] !== 1'b1 && n < 100);
        if (n >= 100) begin n_mismatch++; test_done(); end
    endtask
    task automatic cnt(input int e);
        k = 0;
        repeat (8) begin @(posedge clk); #1 k += int'(sen); end
        chk(k, e);
    endtask
    // hang guard
    initial begin repeat (20000) @(posedge clk); n_mismatch++; test_done(); end
    initial begin
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        #1 chk({pin, oe, sgd}, {sdo, sdo_oe, 1'b0});
        apb(0, `ADC_STAT_OFS, 0); chk(rd[0], 0);
        ok <= 1'b1;
        apb(0, `ADC_OVR_OFS, 0); chk(rd, `ADC_OVR_RST);
        apb(1, `ADC_CTRL_OFS, 32'h2); #1 chk(sgd, 1);
        @(posedge clk) sysref <= 1'b0;
        #1 chk(sgd, 0);
        apb(0, 12'h010, 0); chk(err, 1); chk(rd, 0);
        apb(1, `ADC_SER_OFS, 32'h375); #1 chk({inv, driver_deemphasis_setting, amp}, 8'hFD);
        apb(1, `ADC_SER_OFS, 32'h142); #1 chk({inv, driver_deemphasis_setting, amp}, 8'h62);
        @(posedge clk) core <= 16'h1234;
        repeat (4) @(posedge clk); #1 chk(rxw, 16'h1234);
        chk(sdata, 16'h1234);
        apb(1, `ADC_CTRL_OFS, 32'h4); sysref <= 1'b1;
        repeat (4) @(posedge clk); #1 chk(rxw, 16'h9234);
        chk(sgd, 0);
        apb(1, `ADC_CTRL_OFS, 32'h1); apb(1, `ADC_OVR_OFS, 32'h1001);
        @(posedge clk) core <= 16'h0000;
        repeat (4) @(posedge clk); #1 chk({pin, oe}, 2'b01);
        for (int i = 0; i <= 9; i++) begin
            @(posedge clk) core <= (i < 9) ? ov[i] : 16'h0000;
            #1 if (i > 0) chk(pin, ex[i-1]);
        end
        poll(0); #1 chk(bga, 1);
        poll(4);
        apb(1, `ADC_CTRL_OFS, 32'h100); #1 chk(pd, 1);
        @(posedge clk);
        apb(0, `ADC_STAT_OFS, 0); chk(rd[0], 0);
        apb(1, `ADC_CTRL_OFS, 32'h0); poll(0);
        apb(1, `ADC_CTRL_OFS, 32'h10); #1 chk(reinit, 1);
        @(posedge clk); #1 chk(reinit, 0);
        cnt(4);
        apb(0, `ADC_STAT_OFS, 0); chk(rd[5], 1);
        apb(1, `ADC_CTRL_OFS, 32'h20); cnt(2);
        apb(1, `ADC_CTRL_OFS, 32'h30); #1 chk(reinit, 0);
        apb(0, `ADC_CTRL_OFS, 0); chk(rd, 32'h20);
        test_done();
    end
endmodule // adc_digital_control_features_tb
`default_nettype wire
